// >>> bench/tb_top.sv
/*
 * Self-checking bench for the touch report framer.
 * Assumes trf_pkg, trf_fifo and trf_framer are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import trf_pkg::*;
    logic       clk = 1'h0;
    logic       rst = 1'h1;
    logic       smp = 1'h0;
    logic       tch = 1'h0;
    logic [9:0] sx = 10'h0;
    logic [9:0] sy = 10'h0;
    logic       sel = 1'h0;
    logic       menu = 1'h0;
    logic       stall = 1'h0;
    logic       usb_sel = 1'h0;
    logic [7:0] rs_d, usb_d;
    logic       rs_v, rs_r, usb_v, usb_r, lnk, busy;
    int         errors = 0;
    int         n_compared = 0;
    always #2.5 clk = ~clk;
    // ==========================
    // Design and hosts
    trf_framer dut_u (
        .i_mclk(clk), .i_rst(rst), .i_sample(smp), .i_touched(tch),
        .i_x(sx), .i_y(sy), .i_link_sel(sel),
        .i_on_screen_settings_menu(menu),
        .o_rs_data(rs_d), .o_rs_valid(rs_v), .i_rs_ready(rs_r),
        .o_usb_data(usb_d), .o_usb_valid(usb_v), .i_usb_ready(usb_r),
        .o_link_usb(lnk), .o_busy(busy));
    trf_host_model h_rs (.i_mclk(clk), .i_rst(rst), .i_data(rs_d),
        .i_valid(rs_v), .i_stall(stall), .o_ready(rs_r));
    trf_host_model h_usb (.i_mclk(clk), .i_rst(rst), .i_data(usb_d),
        .i_valid(usb_v), .i_stall(stall), .o_ready(usb_r));
    // ==========================
    // Checks and drivers
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp);
        n_compared++;
        if (got != exp)
        begin
            errors++;
            $display("CHECK FAILED %0t: count %0d want %0d", $time, got, exp);
        end
    endtask
    task automatic take(input logic [7:0] e);
        logic [7:0] b;
        b = 8'hXX;
        for (int i = 0; i < 200; i++)
        begin
            if ((usb_sel ? h_usb.rx_q.size() : h_rs.rx_q.size()) > 0)
            begin
                b = usb_sel ? h_usb.rx_q.pop_front() : h_rs.rx_q.pop_front();
                break;
            end
            @(negedge clk);
        end
        chk_byte(b, e);
    endtask
    task automatic exp_rep(input logic [9:0] x, input logic [9:0] y);
        take(TRF_HDR_TOUCH);
        take({6'h0, x[9:8]});
        take(x[7:0]);
        take({6'h0, y[9:8]});
        take(y[7:0]);
    endtask
    task automatic quiet();
        repeat (40) @(negedge clk);
        chk_cnt(h_rs.rx_q.size() + h_usb.rx_q.size(), 0);
    endtask
    task automatic send(input logic t, input logic [9:0] x, input logic [9:0] y);
        @(negedge clk);
        smp = 1'h1;
        tch = t;
        sx = x;
        sy = y;
        @(negedge clk);
        smp = 1'h0;
        @(negedge clk);
        for (int i = 0; i < 100 && busy === 1'h1; i++)
            @(negedge clk);
    endtask
    task automatic do_reset(input logic s);
        @(negedge clk);
        rst = 1'h1;
        sel = s;
        repeat (10) @(negedge clk);
        rst = 1'h0;
        repeat (3) @(negedge clk);
    endtask
    task automatic release_chk();
        send(1'h0, 10'h0, 10'h0);
        take(TRF_HDR_RELEASE);
    endtask
    // ==========================
    // Scenarios
    task automatic t_touch();
        chk_byte({7'h0, lnk}, 8'h0);
        send(1'h0, 10'h0, 10'h0);
        quiet();
        send(1'h1, 10'h017, 10'h1F4);
        send(1'h1, 10'h017, 10'h1F4);
        send(1'h1, 10'h018, 10'h1F5);
        exp_rep(10'h017, 10'h1F4);
        exp_rep(10'h017, 10'h1F4);
        exp_rep(10'h018, 10'h1F5);
        send(1'h1, 10'h000, 10'h000);
        exp_rep(10'h000, 10'h000);
        send(1'h1, 10'h3FF, 10'h3FF);
        exp_rep(10'h3FF, 10'h3FF);
        release_chk();
        send(1'h0, 10'h0, 10'h0);
        quiet();
    endtask
    task automatic t_menu();
        menu = 1'h1;
        send(1'h1, 10'h005, 10'h006);
        quiet();
        menu = 1'h0;
        send(1'h1, 10'h005, 10'h006);
        exp_rep(10'h005, 10'h006);
        // Release sample seen during the menu is dropped; the next release sample after it closes sends 10h
        menu = 1'h1;
        send(1'h0, 10'h0, 10'h0);
        quiet();
        menu = 1'h0;
        release_chk();
    endtask
    task automatic t_stall();
        stall = 1'h1;
        for (int k = 0; k < 4; k++)
            send(1'h1, 10'(k), 10'(k + 16));
        chk_byte({7'h0, busy}, 8'h1);
        chk_cnt(h_rs.rx_q.size(), 0);
        stall = 1'h0;
        for (int k = 0; k < 4; k++)
            exp_rep(10'(k), 10'(k + 16));
        release_chk();
    endtask
    task automatic t_link();
        sel = 1'h1;
        send(1'h1, 10'h007, 10'h008);
        exp_rep(10'h007, 10'h008);
        release_chk();
        chk_cnt(h_usb.rx_q.size(), 0);
        do_reset(1'h1);
        usb_sel = 1'h1;
        chk_byte({7'h0, lnk}, 8'h1);
        // A stalled USB host makes the framer hold each byte
        stall = 1'h1;
        send(1'h1, 10'h009, 10'h00A);
        stall = 1'h0;
        exp_rep(10'h009, 10'h00A);
        release_chk();
        chk_cnt(h_rs.rx_q.size(), 0);
        chk_cnt(h_rs.bad + h_usb.bad, 0);
    endtask
    task automatic stop_test();
        if (errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        errors++;
        stop_test();
    end
    initial
    begin
        do_reset(1'h0);
        t_touch();
        t_menu();
        t_stall();
        t_link();
        stop_test();
    end
endmodule
`default_nettype wire

// >>> bench/trf_host_model.sv
/*
 * Host side of one link: takes bytes by valid/ready and parses reports.
 * Assumes the framer holds valid and data until ready is sampled high.
 */
`timescale 1ns/100ps
`default_nettype none
module trf_host_model (
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_data,
    input  wire logic       i_valid,
    input  wire logic       i_stall,
    output logic            o_ready
);
    // ==========================
    // Receive and parse
    logic [7:0] rx_q[$];
    int         left = 0;
    int         bad = 0;
    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_ready <= 1'h0;
            left    <= 0;
        end
        else
        begin
            // Stall lets the bench act as a slow host
            o_ready <= !i_stall;
            if (i_valid && o_ready)
            begin
                rx_q.push_back(i_data);
                if (left > 0)
                    left <= left - 1;
                else if (i_data == 8'h11)
                    left <= 4;
                else if (i_data != 8'h10)
                    bad <= bad + 1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verilog/trf_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; the reader may stall at will.
 */
`timescale 1ns/100ps
`default_nettype none
module trf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_valid,
    output logic                  o_ready,
    output logic [WIDTH-1:0]      o_data,
    output logic                  o_valid,
    input  wire logic             i_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } trf_fifo_regs_t;

    trf_fifo_regs_t s_q;
    trf_fifo_regs_t s_d;
    logic           wr;
    logic           rd;

    // Full and empty come from the count alone, so pointers need no wrap bit
    assign o_ready = (s_q.cnt != DEPTH[AW:0]);
    assign o_valid = (s_q.cnt != '0);
    assign o_data  = s_q.mem[s_q.rp];
    assign wr      = i_valid && o_ready;
    assign rd      = o_valid && i_ready;

    always_comb
    begin
        s_d = s_q;
        if (wr)
        begin
            s_d.mem[s_q.wp] = i_data;
            s_d.wp          = s_q.wp + 1'b1;
        end
        if (rd)
        begin
            s_d.rp = s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/trf_framer.sv
/*
 * Touch report framer: turns contact samples into header + X + Y byte
 * reports and steers the byte stream to the RS-232C or USB link.
 * Assumes the digitiser gives calibrated 10-bit coordinates with a
 * one-cycle sample strobe, and each link accepts bytes by valid/ready.
 */
// Behaviour
// (RULE1) Header 11h while touched, 10h once contact is released.
// (RULE2) X sent as two bytes after header, range 0 to 3FFh.
// (RULE3) Both axes resolve 1024 steps across the panel.
// (RULE4) Origin upper-left; X grows rightward, Y grows downward.
// (RULE5) Order: header, X high, X low, Y high, Y low.
// (RULE6) Held contact keeps producing touched reports with same coordinates.
// (RULE7) Moving contact produces touched reports with new coordinates.
// (RULE8) Release byte 10h sent once after last report, then silence.
// (RULE9) Reports go to USB or RS-232C by switch; RS-232C default.
// (RULE10) Link switch sampled only at reset release.
// (RULE11) No reports while the on-screen settings menu is active; code only blocks new reports, one in flight still goes out.
// (RULE12) Y sent as two bytes after X, range 0 to 3FFh.
// (RULE13) Host parses 11h as five-byte report, lone 10h as release.
`timescale 1ns/100ps
`default_nettype none
module trf_framer
    import trf_pkg::*;
(
    input  wire logic                          i_mclk,
    input  wire logic                          i_rst,
    input  wire logic                          i_sample,
    input  wire logic                          i_touched,
    input  wire logic [trf_pkg::TRF_COORD_W-1:0] i_x,
    input  wire logic [trf_pkg::TRF_COORD_W-1:0] i_y,
    input  wire logic                          i_link_sel,
    input  wire logic                          i_on_screen_settings_menu,
    output logic      [trf_pkg::TRF_BYTE_W-1:0]  o_rs_data,
    output logic                               o_rs_valid,
    input  wire logic                          i_rs_ready,
    output logic      [trf_pkg::TRF_BYTE_W-1:0]  o_usb_data,
    output logic                               o_usb_valid,
    input  wire logic                          i_usb_ready,
    output logic                               o_link_usb,
    output logic                               o_busy
);
    import trf_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        trf_state_t                st;
        logic                      strap_done;
        logic                      link;
        logic                      was_touched;
        logic [TRF_COORD_W-1:0]    x;
        logic [TRF_COORD_W-1:0]    y;
        logic [TRF_BYTE_W-1:0]     rs_data;
        logic                      rs_valid;
        logic [TRF_BYTE_W-1:0]     usb_data;
        logic                      usb_valid;
        logic                      busy;
    } trf_regs_t;

    trf_regs_t s_q;
    trf_regs_t s_d;

    logic [TRF_BYTE_W-1:0] f_wdata;
    logic                  f_wvalid;
    logic                  f_wready;
    logic [TRF_BYTE_W-1:0] f_rdata;
    logic                  f_rvalid;
    logic                  f_rready;
    logic                  out_free;

    // Pads a coordinate into its high byte (MSB first on the wire)
    function automatic logic [TRF_BYTE_W-1:0] hi_byte(
        input logic [TRF_COORD_W-1:0] c);
        hi_byte = {6'h00, c[9:8]};
    endfunction

    // ==========================================================
    // Byte FIFO
    trf_fifo #(
        .WIDTH (TRF_BYTE_W),
        .DEPTH (TRF_FIFO_DEPTH)
    ) u_fifo (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_data  (f_wdata),
        .i_valid (f_wvalid),
        .o_ready (f_wready),
        .o_data  (f_rdata),
        .o_valid (f_rvalid),
        .i_ready (f_rready)
    );

    // Output stage is free when its holding register is empty or leaving
    assign out_free = s_q.link ? (!s_q.usb_valid || i_usb_ready)
                               : (!s_q.rs_valid || i_rs_ready);
    assign f_rready = out_free && s_q.strap_done;

    // ==========================================================
    // Next state
    always_comb
    begin
        s_d      = s_q;
        f_wdata  = '0;
        f_wvalid = 1'b0;

        // Strap caught once, on the first clock after reset release
        if (!s_q.strap_done)
        begin
            s_d.strap_done = 1'b1;
            s_d.link       = i_link_sel; // RULE9 RULE10
        end

        // Link output holding registers
        if (i_rs_ready)
        begin
            s_d.rs_valid = 1'b0;
        end
        if (i_usb_ready)
        begin
            s_d.usb_valid = 1'b0;
        end
        if (f_rvalid && f_rready)
        begin
            if (s_q.link == TRF_LINK_USB)
            begin
                s_d.usb_data  = f_rdata; // RULE9
                s_d.usb_valid = 1'b1;
            end
            else
            begin
                s_d.rs_data  = f_rdata;
                s_d.rs_valid = 1'b1;
            end
        end

        unique case (s_q.st)
            TRF_IDLE:
            begin
                // Menu blocks new reports; a report in flight still ends
                if (i_sample && !i_on_screen_settings_menu) // RULE11
                begin
                    if (i_touched)
                    begin
                        // Coordinates latched so a report never tears
                        s_d.x           = i_x; // RULE3 RULE4 RULE7
                        s_d.y           = i_y; // RULE6
                        s_d.was_touched = 1'b1;
                        s_d.st          = TRF_HDR;
                    end
                    else if (s_q.was_touched)
                    begin
                        s_d.was_touched = 1'b0;
                        s_d.st          = TRF_REL; // RULE8
                    end
                end
            end
            TRF_HDR:
            begin
                f_wdata  = TRF_HDR_TOUCH; // RULE1 RULE5
                f_wvalid = 1'b1;
                if (f_wready)
                begin
                    s_d.st = TRF_XH;
                end
            end
            TRF_XH:
            begin
                f_wdata  = hi_byte(s_q.x); // RULE2 RULE5
                f_wvalid = 1'b1;
                if (f_wready)
                begin
                    s_d.st = TRF_XL;
                end
            end
            TRF_XL:
            begin
                f_wdata  = s_q.x[7:0]; // RULE2
                f_wvalid = 1'b1;
                if (f_wready)
                begin
                    s_d.st = TRF_YH;
                end
            end
            TRF_YH:
            begin
                f_wdata  = hi_byte(s_q.y); // RULE12 RULE5
                f_wvalid = 1'b1;
                if (f_wready)
                begin
                    s_d.st = TRF_YL;
                end
            end
            TRF_YL:
            begin
                f_wdata  = s_q.y[7:0]; // RULE12
                f_wvalid = 1'b1;
                if (f_wready)
                begin
                    s_d.st = TRF_IDLE;
                end
            end
            TRF_REL:
            begin
                f_wdata  = TRF_HDR_RELEASE; // RULE1 RULE8
                f_wvalid = 1'b1;
                if (f_wready)
                begin
                    s_d.st = TRF_IDLE;
                end
            end
            default:
            begin
                s_d.st = TRF_IDLE;
            end
        endcase

        // Registered so the busy output comes straight from a flip-flop
        s_d.busy = (s_d.st != TRF_IDLE);
    end

    // ==========================================================
    // Registers
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s_q <= '{st: TRF_IDLE, strap_done: 1'b0, link: TRF_LINK_RS232,
                     was_touched: 1'b0, x: '0, y: '0, rs_data: '0,
                     rs_valid: 1'b0, usb_data: '0, usb_valid: 1'b0,
                     busy: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_rs_data   = s_q.rs_data;
    assign o_rs_valid  = s_q.rs_valid;
    assign o_usb_data  = s_q.usb_data;
    assign o_usb_valid = s_q.usb_valid;
    assign o_link_usb  = s_q.link;
    assign o_busy      = s_q.busy;

    // ==========================================================
    // Checks
    a_hdr_first: assert property ( // RULE1
        @(posedge i_mclk) disable iff (i_rst)
        s_q.st == TRF_IDLE && i_sample && i_touched
        && !i_on_screen_settings_menu |=> s_q.st == TRF_HDR)
        else $error("touch sample did not start a header");
    a_x_range: assert property ( // RULE2
        @(posedge i_mclk) disable iff (i_rst)
        s_q.st == TRF_XH |-> f_wdata[7:2] == 6'h00)
        else $error("x high byte above 3FFh");
    a_y_range: assert property ( // RULE12
        @(posedge i_mclk) disable iff (i_rst)
        s_q.st == TRF_YH |-> f_wdata[7:2] == 6'h00)
        else $error("y high byte above 3FFh");
    // Each byte slot advances only on an accepted write, one slot at a time
    a_byte_order: assert property ( // RULE5
        @(posedge i_mclk) disable iff (i_rst)
        s_q.st == TRF_HDR && f_wready |=> s_q.st == TRF_XH)
        else $error("header not followed by x high byte");
    a_xh_order: assert property ( // RULE5
        @(posedge i_mclk) disable iff (i_rst)
        s_q.st == TRF_XH && f_wready |=> s_q.st == TRF_XL)
        else $error("x high byte not followed by x low byte");
    a_xl_order: assert property ( // RULE5
        @(posedge i_mclk) disable iff (i_rst)
        s_q.st == TRF_XL && f_wready |=> s_q.st == TRF_YH)
        else $error("x low byte not followed by y high byte");
    a_yh_order: assert property ( // RULE5
        @(posedge i_mclk) disable iff (i_rst)
        s_q.st == TRF_YH && f_wready |=> s_q.st == TRF_YL)
        else $error("y high byte not followed by y low byte");
    a_yl_last: assert property ( // RULE5
        @(posedge i_mclk) disable iff (i_rst)
        s_q.st == TRF_YL && f_wready |=> s_q.st == TRF_IDLE)
        else $error("report longer than five bytes");
    // A full FIFO must freeze the report, never skip a byte
    a_wr_stall: assert property ( // RULE5
        @(posedge i_mclk) disable iff (i_rst)
        s_q.st != TRF_IDLE && !f_wready |=> $stable(s_q.st))
        else $error("report advanced while the FIFO was full");
    a_rel_once: assert property ( // RULE8
        @(posedge i_mclk) disable iff (i_rst)
        s_q.st == TRF_REL && f_wready |=> s_q.st == TRF_IDLE
        && !s_q.was_touched)
        else $error("release byte not single");
    a_rel_guard: assert property ( // RULE8
        @(posedge i_mclk) disable iff (i_rst)
        s_q.st == TRF_IDLE && i_sample && !i_touched
        && !s_q.was_touched |=> s_q.st == TRF_IDLE)
        else $error("release sent without a prior touch");
    a_menu_block: assert property ( // RULE11
        @(posedge i_mclk) disable iff (i_rst)
        s_q.st == TRF_IDLE && i_on_screen_settings_menu
        |=> s_q.st == TRF_IDLE)
        else $error("report started during settings menu");
    a_link_fixed: assert property ( // RULE10
        @(posedge i_mclk) disable iff (i_rst)
        s_q.strap_done && $past(s_q.strap_done) |-> $stable(s_q.link))
        else $error("link selection changed after power-up");
    a_link_route: assert property ( // RULE9
        @(posedge i_mclk) disable iff (i_rst)
        s_q.link == TRF_LINK_RS232 |-> !s_q.usb_valid)
        else $error("byte sent on unselected usb link");
    a_usb_only: assert property ( // RULE9
        @(posedge i_mclk) disable iff (i_rst)
        s_q.link == TRF_LINK_USB |-> !s_q.rs_valid)
        else $error("byte sent on unselected serial link");
    // A stalled host must see the same byte until it takes it
    a_rs_hold: assert property ( // RULE9
        @(posedge i_mclk) disable iff (i_rst)
        s_q.rs_valid && !i_rs_ready
        |=> s_q.rs_valid && $stable(s_q.rs_data))
        else $error("serial byte dropped or changed while stalled");
    a_usb_hold: assert property ( // RULE9
        @(posedge i_mclk) disable iff (i_rst)
        s_q.usb_valid && !i_usb_ready
        |=> s_q.usb_valid && $stable(s_q.usb_data))
        else $error("usb byte dropped or changed while stalled");
    a_coord_hold: assert property ( // RULE6
        @(posedge i_mclk) disable iff (i_rst)
        s_q.st != TRF_IDLE && s_q.st != TRF_REL |=> $stable(s_q.x)
        && $stable(s_q.y))
        else $error("coordinates changed inside a report");
endmodule
`default_nettype wire

// >>> verilog/trf_pkg.sv
/*
 * Constants shared by the touch report framer and its byte FIFO.
 * Assumes a single 200 MHz clock domain.
 */
package trf_pkg;
    localparam logic [7:0]  TRF_HDR_TOUCH   = 8'h11;
    localparam logic [7:0]  TRF_HDR_RELEASE = 8'h10;
    localparam int          TRF_COORD_W     = 10;
    localparam logic [9:0]  TRF_COORD_MAX   = 10'h3FF;
    localparam int          TRF_BYTE_W      = 8;
    localparam int          TRF_FIFO_DEPTH  = 16;
    localparam int          TRF_REPORT_LEN  = 5;
    localparam logic        TRF_LINK_RS232  = 1'b0;
    localparam logic        TRF_LINK_USB    = 1'b1;
    typedef enum logic [2:0] {
        TRF_IDLE, TRF_HDR, TRF_XH, TRF_XL, TRF_YH, TRF_YL, TRF_REL
    } trf_state_t;
endpackage
